// ### dv/bsm_chk.sv
// Port-level assertions for the tester and register bus
`timescale 1ns/10ps
`default_nettype none
module bsm_chk
	import bsm_pkg::*;
(
	input wire logic        CLK_SYS,
	input wire logic        RST_B,
	input wire logic        CE,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [7:0]  WB_ADR_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	input wire logic        BIT_STB,
	input wire logic        SEC_PRESENT,
	input wire logic [1:0]  LOCAL_LOOP_STATE,
	input wire logic        TST_TX_BIT,
	input wire logic        TST_NET_EN,
	input wire logic        TST_USER_EN,
	input wire logic        TST_SEC_SEL
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	logic rd_ack;
	assign rd_ack = WB_ACK_O && !WB_WE_I;
	ack_pulse_a: assert property (WB_ACK_O && CE |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	ack_time_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && CE |=> WB_ACK_O)
		else $error("ack late");
	ack_cause_a: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
		else $error("ack without request");
	en_excl_a: assert property (!(TST_NET_EN && TST_USER_EN))
		else $error("both directions enabled");
	sec_force_a: assert property (!SEC_PRESENT [*2] |-> !TST_SEC_SEL)
		else $error("secondary without channel");
	tx_hold_a: assert property (!BIT_STB |=> $stable(TST_TX_BIT))
		else $error("test bit moved between slots");
	zero_read_a: assert property (rd_ack && (WB_ADR_I[7:2] == BSM_ADR_CMD[7:2] || WB_ADR_I > 8'h43)
		|-> WB_DAT_O == 32'h0) else $error("nonzero read of hole");
	stat_pins_a: assert property (rd_ack && WB_ADR_I[7:2] == BSM_ADR_STAT[7:2] |->
		WB_DAT_O[2:1] == $past(LOCAL_LOOP_STATE) && WB_DAT_O[7] == $past(SEC_PRESENT))
		else $error("status pins wrong");
	ctrl_en_a: assert property (rd_ack && WB_ADR_I[7:2] == BSM_ADR_CTRL[7:2] |->
		TST_NET_EN == (WB_DAT_O[2:0] != 3'h0 && !WB_DAT_O[3])
		&& TST_USER_EN == (WB_DAT_O[2:0] != 3'h0 && WB_DAT_O[3]))
		else $error("enables disagree with control");
	cover property (WB_ACK_O && WB_WE_I);
	cover property (TST_USER_EN && TST_SEC_SEL);
	cover property (BIT_STB && TST_NET_EN);
endmodule : bsm_chk
bind bsm_top bsm_chk chk_u (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O), .BIT_STB(BIT_STB), .SEC_PRESENT(SEC_PRESENT), .LOCAL_LOOP_STATE(LOCAL_LOOP_STATE),
	.TST_TX_BIT(TST_TX_BIT), .TST_NET_EN(TST_NET_EN), .TST_USER_EN(TST_USER_EN), .TST_SEC_SEL(TST_SEC_SEL));
`default_nettype wire

// ### dv/bsm_line_model.sv
// Far-side model: looping line path and correction-stage strobes
`timescale 1ns/10ps
`default_nettype none
module bsm_line_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       tx,
	input  wire logic       net_en,
	input  wire logic       user_en,
	input  wire logic       sec_sel,
	input  wire logic       brk,
	input  wire logic [1:0] ferr,
	output logic            bit_stb,
	output logic            net_pri,
	output logic            net_sec,
	output logic            user_pri,
	output logic            user_sec,
	output logic            fec_in_err,
	output logic            fec_out_err
);
	logic [1:0] div_q;
	logic       tog_q;
	logic       lb;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_q <= 2'h0;
			tog_q <= 1'b0;
		end else begin
			div_q <= div_q + 2'h1;
			tog_q <= ~tog_q;
		end
	end
	assign bit_stb = (div_q == 2'h3);
	assign fec_in_err = bit_stb & ferr[0];
	assign fec_out_err = bit_stb & ferr[1];
	// Broken loop returns the inverse
	assign lb = tx ^ brk;
	// Unselected lines toggle so stale data never looks valid
	assign net_pri = (net_en && !sec_sel) ? lb : tog_q;
	assign net_sec = (net_en && sec_sel) ? lb : tog_q;
	assign user_pri = (user_en && !sec_sel) ? lb : tog_q;
	assign user_sec = (user_en && sec_sel) ? lb : tog_q;
endmodule : bsm_line_model
`default_nettype wire

// ### dv/bsm_top_tb.sv
// Register-level bench for the tester and second counters
`timescale 1ns/10ps
`default_nettype none
module bsm_top_tb
	import bsm_pkg::*;
;
	localparam int TK = 200;
	logic        CLK_SYS = 1'b0;
	logic        RST_B = 1'b0;
	logic        req = 1'b0;
	logic        wen = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, rd_v, v;
	logic        ack, bstb, np, ns, up, us, fin, fout, tx, nen, uen, ssel;
	logic        sec_p = 1'b0;
	logic        fw = 1'b0;
	logic        brk = 1'b0;
	logic [1:0]  lst = 2'h0;
	logic [1:0]  ferr = 2'h0;
	logic [63:0] q;
	int          errors = 0;
	int          samples_checked = 0;
	int          cyc_cnt = 0;
	always #5 CLK_SYS = ~CLK_SYS;
	// Bus cycle and strobe are tied, select is all ones: every write carries byte 0
	bsm_top #(.TICK_CYCLES(TK)) dut_u (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(1'b1), .WB_CYC_I(req),
		.WB_STB_I(req), .WB_WE_I(wen), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .BIT_STB(bstb), .NET_PRI_RX(np), .NET_SEC_RX(ns), .USER_PRI_RX(up), .USER_SEC_RX(us),
		.SEC_PRESENT(sec_p), .FEC_BIT_STB(bstb), .FEC_IN_ERR(fin), .FEC_OUT_ERR(fout),
		.LOCAL_LOOP_STATE(lst), .FOUR_WIRE_SIGNAL(fw), .TST_TX_BIT(tx), .TST_NET_EN(nen),
		.TST_USER_EN(uen), .TST_SEC_SEL(ssel));
	bsm_line_model line_u (.clk(CLK_SYS), .rst_b(RST_B), .tx(tx), .net_en(nen), .user_en(uen),
		.sec_sel(ssel), .brk(brk), .ferr(ferr), .bit_stb(bstb), .net_pri(np), .net_sec(ns),
		.user_pri(up), .user_sec(us), .fec_in_err(fin), .fec_out_err(fout));
	task automatic report_and_stop;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		req <= 1'b1;
		wen <= w;
		adr <= a;
		wdat <= d;
		// Only the cycle ceiling ends a wait for ack
		do begin
			@(posedge CLK_SYS);
		end while (ack !== 1'b1);
		rd_v = rdat;
		req <= 1'b0;
	endtask : wb
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, rd_v, e);
	endtask : rc
	task automatic wt(input int n);
		repeat (n) @(posedge CLK_SYS);
	endtask : wt
	always @(posedge CLK_SYS) begin
		cyc_cnt++;
		if (cyc_cnt == 40000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		wt(12);
		RST_B <= 1'b1;
		rc("ctrl", BSM_ADR_CTRL, 32'h0);
		rc("hole", 8'hFC, 32'h0);
		for (int i = 0; i < 3; i++) begin
			lst <= i[1:0];
			fw <= i[0];
			wt(4);
			wb(1'b0, BSM_ADR_STAT, 32'h0);
			chk("stat", {29'h0, rd_v[3:1]}, {29'h0, i[0], i[1:0]});
		end
		lst <= 2'h0;
		for (int p = 1; p < 8; p++) begin
			// Pattern off first, so every pattern must lock from scratch
			wb(1'b1, BSM_ADR_CTRL, 32'h0);
			wb(1'b1, BSM_ADR_CTRL, p);
			wt(800);
			wb(1'b0, BSM_ADR_STAT, 32'h0);
			chk("sync", {31'h0, rd_v[0]}, 32'h1);
		end
		// Equal spacing between paired reads keeps the tick phase fixed
		wb(1'b0, BSM_ADR_SECS, 32'h0);
		v = rd_v;
		wb(1'b0, BSM_ADR_UNSYNC, 32'h0);
		q[31:0] = rd_v;
		wt(994);
		rc("secs", BSM_ADR_SECS, v + 32'h5);
		rc("unsync", BSM_ADR_UNSYNC, q[31:0]);
		wb(1'b1, BSM_ADR_CTRL, 32'h6);
		wt(800);
		wb(1'b1, BSM_ADR_CMD, 32'h2);
		wt(TK);
		wb(1'b1, BSM_ADR_CMD, 32'h1);
		wt(2 * TK);
		wb(1'b0, BSM_ADR_TES, 32'h0);
		v = rd_v;
		chk("es", {31'h0, v == 32'h1 || v == 32'h2}, 32'h1);
		rc("ses", BSM_ADR_TSES, v);
		wb(1'b0, BSM_ADR_BERR, 32'h0);
		chk("berr", {31'h0, rd_v >= 32'h1 && rd_v <= 32'h3}, 32'h1);
		wb(1'b1, BSM_ADR_CTRL, 32'h0);
		wt(300);
		wb(1'b0, BSM_ADR_BERR, 32'h0);
		v = rd_v;
		wb(1'b0, BSM_ADR_BITS, 32'h0);
		q = ({32'h0, v} << 24) / {32'h0, rd_v};
		rc("ber", BSM_ADR_BER, q[31:0]);
		wb(1'b1, BSM_ADR_CMD, 32'h2);
		wt(300);
		rc("berr0", BSM_ADR_BERR, 32'h0);
		rc("es0", BSM_ADR_TES, 32'h0);
		rc("secs0", BSM_ADR_SECS, 32'h0);
		rc("ber0", BSM_ADR_BER, 32'h0);
		sec_p <= 1'b1;
		wb(1'b1, BSM_ADR_CTRL, 32'h1D);
		wt(800);
		rc("ctrl", BSM_ADR_CTRL, 32'h1D);
		chk("route", {30'h0, uen, ssel}, 32'h3);
		rc("stat", BSM_ADR_STAT, 32'h81);
		wb(1'b1, BSM_ADR_CTRL, 32'h0);
		sec_p <= 1'b0;
		wb(1'b1, BSM_ADR_CTRL, 32'h15);
		rc("ctrl", BSM_ADR_CTRL, 32'h5);
		brk <= 1'b1;
		wt(600);
		wb(1'b0, BSM_ADR_UNSYNC, 32'h0);
		v = rd_v;
		wt(997);
		rc("unsync", BSM_ADR_UNSYNC, v + 32'h5);
		rc("stat", BSM_ADR_STAT, 32'h0);
		brk <= 1'b0;
		wb(1'b1, BSM_ADR_CTRL, 32'h40);
		wb(1'b1, BSM_ADR_CMD, 32'h4);
		ferr <= 2'h3;
		wt(13 * TK);
		wb(1'b0, BSM_ADR_STAT, 32'h0);
		chk("run", {30'h0, rd_v[5:4]}, 32'h3);
		wb(1'b0, BSM_ADR_IN_ES, 32'h0);
		rc("in_sev", BSM_ADR_IN_SEV, rd_v);
		wb(1'b0, BSM_ADR_IN_RUN, 32'h0);
		chk("in_run", {31'h0, rd_v >= 32'h1}, 32'h1);
		ferr <= 2'h0;
		wt(12 * TK);
		wb(1'b0, BSM_ADR_STAT, 32'h0);
		chk("run", {30'h0, rd_v[5:4]}, 32'h0);
		wb(1'b0, BSM_ADR_OUT_ES, 32'h0);
		chk("out_es", {31'h0, rd_v >= 32'hC}, 32'h1);
		rc("out_sev", BSM_ADR_OUT_SEV, rd_v);
		wb(1'b1, BSM_ADR_CTRL, 32'h20);
		wb(1'b1, BSM_ADR_CMD, 32'h4);
		ferr <= 2'h3;
		wt(3 * TK);
		rc("out_es", BSM_ADR_OUT_ES, 32'h0);
		wb(1'b0, BSM_ADR_IN_ES, 32'h0);
		chk("in_es", {31'h0, rd_v >= 32'h2}, 32'h1);
		wb(1'b1, BSM_ADR_CTRL, 32'h0);
		wb(1'b1, BSM_ADR_CMD, 32'h4);
		wt(3 * TK);
		rc("in_es", BSM_ADR_IN_ES, 32'h0);
		// One injected error per second on a steady pattern keeps every second severe
		wb(1'b1, BSM_ADR_CTRL, 32'h1);
		wt(800);
		for (int k = 0; k < 12; k++) begin
			wb(1'b1, BSM_ADR_CMD, 32'h1);
			wt(TK - 3);
		end
		wb(1'b0, BSM_ADR_STAT, 32'h0);
		chk("t_run", {31'h0, rd_v[6]}, 32'h1);
		wb(1'b0, BSM_ADR_TCSES, 32'h0);
		chk("tcses", {31'h0, rd_v >= 32'h1}, 32'h1);
		report_and_stop();
	end
endmodule : bsm_top_tb
`default_nettype wire

// ### verilog/bsm_pkg.sv
// Constants, register map and state type for the test and error-second monitor
package bsm_pkg;

	// Second tick timing
	localparam int unsigned BSM_CLK_PERIOD_NS = 10;
	localparam int unsigned BSM_SECOND_NS     = 1000000000;
	localparam int unsigned BSM_TICK_CYCLES   = BSM_SECOND_NS / BSM_CLK_PERIOD_NS;

	// Register byte addresses
	localparam logic [7:0] BSM_ADR_CTRL    = 8'h00;
	localparam logic [7:0] BSM_ADR_CMD     = 8'h04;
	localparam logic [7:0] BSM_ADR_STAT    = 8'h08;
	localparam logic [7:0] BSM_ADR_BERR    = 8'h0C;
	localparam logic [7:0] BSM_ADR_TES     = 8'h10;
	localparam logic [7:0] BSM_ADR_TSES    = 8'h14;
	localparam logic [7:0] BSM_ADR_TCSES   = 8'h18;
	localparam logic [7:0] BSM_ADR_UNSYNC  = 8'h1C;
	localparam logic [7:0] BSM_ADR_SECS    = 8'h20;
	localparam logic [7:0] BSM_ADR_BER     = 8'h24;
	localparam logic [7:0] BSM_ADR_BITS    = 8'h28;
	localparam logic [7:0] BSM_ADR_IN_ES   = 8'h2C;
	localparam logic [7:0] BSM_ADR_IN_SEV  = 8'h30;
	localparam logic [7:0] BSM_ADR_IN_RUN  = 8'h34;
	localparam logic [7:0] BSM_ADR_OUT_ES  = 8'h38;
	localparam logic [7:0] BSM_ADR_OUT_SEV = 8'h3C;
	localparam logic [7:0] BSM_ADR_OUT_RUN = 8'h40;

	// Field positions
	localparam int unsigned BSM_CTRL_PAT_LSB = 0;
	localparam int unsigned BSM_CTRL_DIR_BIT = 3;
	localparam int unsigned BSM_CTRL_SEC_BIT = 4;
	localparam int unsigned BSM_CTRL_FEC_LSB = 5;
	localparam int unsigned BSM_CMD_INJ_BIT  = 0;
	localparam int unsigned BSM_CMD_TCLR_BIT = 1;
	localparam int unsigned BSM_CMD_PCLR_BIT = 2;

	// Reset values
	localparam logic BSM_DIR_NET_RST = 1'b0;
	localparam logic BSM_SEC_RST     = 1'b0;

	// Loop state codes
	localparam logic [1:0] BSM_LOOP_NONE = 2'h0;
	localparam logic [1:0] BSM_LOOP_TERM = 2'h1;
	localparam logic [1:0] BSM_LOOP_NET  = 2'h2;

	// Counting thresholds
	localparam logic [3:0]  BSM_CSES_RUN      = 4'hA;
	localparam logic [33:0] BSM_SES_RATIO     = 34'h3E8;
	localparam logic [5:0]  BSM_SYNC_GOOD_LST = 6'h1F;
	localparam logic [6:0]  BSM_WIN_LAST      = 7'h7F;
	localparam logic [3:0]  BSM_LOSS_ERRS     = 4'h8;
	localparam logic [5:0]  BSM_DIV_STEPS     = 6'h38;

	typedef enum logic [2:0] {
		PAT_OFF   = 3'h0,
		PAT_MARK  = 3'h1,
		PAT_SPACE = 3'h2,
		PAT_ALT   = 3'h3,
		PAT_ONE8  = 3'h4,
		PAT_P511  = 3'h5,
		PAT_P2047 = 3'h6,
		PAT_QRSS  = 3'h7
	} bsm_pat_e;

	typedef enum logic [1:0] {
		FEC_NONE = 2'h0,
		FEC_MAJ  = 2'h1,
		FEC_BCH  = 2'h2
	} bsm_fec_e;

	typedef struct packed {
		logic [26:0] tick_cnt;
		logic        ack;
		logic [31:0] rdat;
		bsm_pat_e    pat;
		logic        dir;
		logic        sec;
		bsm_fec_e    fec;
		logic        inj_pend;
		logic        tx_bit;
		logic [19:0] tx_hist;
		logic [19:0] rx_hist;
		logic        sync;
		logic [5:0]  good_cnt;
		logic [6:0]  win_cnt;
		logic [3:0]  win_err;
		logic [31:0] be_tot;
		logic [31:0] bits_tot;
		logic        t_err_flag;
		logic        t_oos_flag;
		logic [23:0] t_err_cnt;
		logic [23:0] t_bit_cnt;
		logic [15:0] t_es;
		logic [15:0] t_ses;
		logic [15:0] t_cses;
		logic [15:0] t_unsync;
		logic [15:0] t_secs;
		logic [3:0]  t_run;
		logic        t_act;
		logic [31:0] ber;
		logic        div_busy;
		logic [5:0]  div_cnt;
		logic [32:0] div_rem;
		logic [55:0] div_num;
		logic [31:0] div_den;
		logic [23:0] i_err_cnt;
		logic [23:0] o_err_cnt;
		logic [23:0] f_bit_cnt;
		logic [15:0] i_es;
		logic [15:0] i_ses;
		logic [15:0] i_cses;
		logic [3:0]  i_run;
		logic        i_act;
		logic [15:0] o_es;
		logic [15:0] o_ses;
		logic [15:0] o_cses;
		logic [3:0]  o_run;
		logic        o_act;
		logic        fw_meta;
		logic        fw_sync;
	} bsm_state_s;

endpackage : bsm_pkg

// ### verilog/bsm_top.sv
// Bit error rate tester and per-second error monitor with a Wishbone register file
//
// Overview of operation
// - Count input errored seconds: any network-side input error in that second.
// - Count input severe seconds: input error ratio above one per thousand.
// - Input consecutive count starts after ten severe seconds, stops after ten clean.
// - Output errored seconds counted only while BCH correction is selected.
// - Output severe seconds, ratio above one per thousand, only under BCH.
// - Output consecutive count, ten-second start and stop, only under BCH.
// - Patterns: off, ones, zeros, 1010, 0100-0000, 511, 2047, quasi-random.
// - Reset defaults: pattern off, direction network, primary channel.
// - Direction chooses network or four-wire user side for the pattern.
// - Primary or secondary channel; secondary only when the port has one.
// - Flag sync when received pattern matches, own loopback or remote tester.
// - Keep a running total of checker bit errors.
// - Tester errored second: any detected pattern error in that second.
// - Tester severe second: error ratio above one per thousand.
// - Tester consecutive count, ten-second start and ten-second stop.
// - Count seconds in which the checker is not synchronised.
// - Report bit error rate as errors divided by bits sent.
// - Count seconds elapsed since the test started.
// - Injection requests pending at a bit slot invert exactly one transmitted test bit.
// - Test clear resets every tester statistic.
// - Expose local loop state: none, toward terminal, toward network.
// - Under majority vote the output counters are not maintained.
`timescale 1ns/10ps
`default_nettype none

module bsm_top
	import bsm_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = BSM_TICK_CYCLES
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_B,
	input  wire logic        CE,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic        BIT_STB,
	input  wire logic        NET_PRI_RX,
	input  wire logic        NET_SEC_RX,
	input  wire logic        USER_PRI_RX,
	input  wire logic        USER_SEC_RX,
	input  wire logic        SEC_PRESENT,
	input  wire logic        FEC_BIT_STB,
	input  wire logic        FEC_IN_ERR,
	input  wire logic        FEC_OUT_ERR,
	input  wire logic [1:0]  LOCAL_LOOP_STATE,
	input  wire logic        FOUR_WIRE_SIGNAL,
	output logic             TST_TX_BIT,
	output logic             TST_NET_EN,
	output logic             TST_USER_EN,
	output logic             TST_SEC_SEL
);

	bsm_state_s s_q;
	bsm_state_s s_d;

	// Pattern next bit from the last bits; shared by generator and checker
	function automatic logic pat_bit(input bsm_pat_e p, input logic [19:0] h);
		logic b;
		b = 1'b0;
		case (p)
			PAT_MARK:  b = 1'b1;
			PAT_SPACE: b = 1'b0;
			PAT_ALT:   b = ~h[0];
			PAT_ONE8:  b = (h[6:0] == 7'h00);
			PAT_P511:  b = (h[8:0] == 9'h000) ? 1'b1 : (h[8] ^ h[4]);
			PAT_P2047: b = (h[10:0] == 11'h000) ? 1'b1 : (h[10] ^ h[8]);
			// Zero runs capped at fourteen, same rule on both ends
			PAT_QRSS:  b = (h[13:0] == 14'h0000) ? 1'b1 : (h[19] ^ h[16]);
			default:   b = 1'b0;
		endcase
		return b;
	endfunction : pat_bit

	// Severe when errors exceed one per thousand bits
	function automatic logic is_severe(input logic [23:0] errs, input logic [23:0] bits);
		return (({10'h000, errs} * BSM_SES_RATIO) > {10'h000, bits});
	endfunction : is_severe

	// Ten-in-a-row start and stop of a consecutive-severe run; returns {active, run}
	function automatic logic [4:0] cses_step(input logic sev, input logic act, input logic [3:0] run);
		logic [3:0] r;
		logic       a;
		a = act;
		r = (sev ^ act) ? run + 4'h1 : 4'h0;
		if (r == BSM_CSES_RUN) begin
			a = ~act;
			r = 4'h0;
		end
		return {a, r};
	endfunction : cses_step

	logic        wb_req;
	logic        tick;
	logic        running;
	logic        rx_bit;
	logic        exp_bit;
	logic        bit_err;
	logic        sev_now;
	logic [4:0]  step;
	logic [32:0] div_try;

	assign wb_req  = WB_CYC_I & WB_STB_I & ~s_q.ack;
	assign tick    = (s_q.tick_cnt == 27'(TICK_CYCLES - 1));
	assign running = (s_q.pat != PAT_OFF);

	always_comb begin
		// returned pattern follows the chosen side
		case ({s_q.dir, s_q.sec})
			2'b00:   rx_bit = NET_PRI_RX;
			2'b01:   rx_bit = NET_SEC_RX;
			2'b10:   rx_bit = USER_PRI_RX;
			default: rx_bit = USER_SEC_RX;
		endcase
	end

	assign exp_bit = pat_bit(s_q.pat, s_q.rx_hist);
	assign bit_err = running & BIT_STB & (rx_bit != exp_bit);

	always_comb begin
		s_d     = s_q;
		sev_now = 1'b0;
		step    = 5'h00;
		div_try = 33'h0;

		// one-second tick from the system clock
		s_d.tick_cnt = tick ? 27'h0 : s_q.tick_cnt + 27'h1;

		// Line detect synchroniser
		s_d.fw_meta = FOUR_WIRE_SIGNAL;
		s_d.fw_sync = s_q.fw_meta;

		// Bus slave, one wait state, unmapped reads return zero
		s_d.ack = wb_req;
		if (wb_req && !WB_WE_I) begin
			case ({WB_ADR_I[7:2], 2'b00})
				BSM_ADR_CTRL:  s_d.rdat = {25'h0, s_q.fec, s_q.sec, s_q.dir, s_q.pat};
				BSM_ADR_STAT:  s_d.rdat = {24'h0, SEC_PRESENT, s_q.t_act, s_q.o_act, s_q.i_act,
							s_q.fw_sync, LOCAL_LOOP_STATE, s_q.sync};
				BSM_ADR_BERR:  s_d.rdat = s_q.be_tot;
				BSM_ADR_TES:   s_d.rdat = {16'h0, s_q.t_es};
				BSM_ADR_TSES:  s_d.rdat = {16'h0, s_q.t_ses};
				BSM_ADR_TCSES: s_d.rdat = {16'h0, s_q.t_cses};
				BSM_ADR_UNSYNC:  s_d.rdat = {16'h0, s_q.t_unsync};
				BSM_ADR_SECS:    s_d.rdat = {16'h0, s_q.t_secs};
				BSM_ADR_BER:     s_d.rdat = s_q.ber;
				BSM_ADR_BITS:    s_d.rdat = s_q.bits_tot;
				BSM_ADR_IN_ES:   s_d.rdat = {16'h0, s_q.i_es};
				BSM_ADR_IN_SEV:  s_d.rdat = {16'h0, s_q.i_ses};
				BSM_ADR_IN_RUN:  s_d.rdat = {16'h0, s_q.i_cses};
				BSM_ADR_OUT_ES:  s_d.rdat = {16'h0, s_q.o_es};
				BSM_ADR_OUT_SEV: s_d.rdat = {16'h0, s_q.o_ses};
				BSM_ADR_OUT_RUN: s_d.rdat = {16'h0, s_q.o_cses};
				default:       s_d.rdat = 32'h0;
			endcase
		end

		// test clear first, so events of the same cycle survive it
		if (wb_req && WB_WE_I && WB_SEL_I[0] && ({WB_ADR_I[7:2], 2'b00} == BSM_ADR_CMD)
				&& WB_DAT_I[BSM_CMD_TCLR_BIT]) begin
			s_d.be_tot     = 32'h0;
			s_d.bits_tot   = 32'h0;
			s_d.t_err_flag = 1'b0;
			s_d.t_oos_flag = 1'b0;
			s_d.t_err_cnt  = 24'h0;
			s_d.t_bit_cnt  = 24'h0;
			s_d.t_es       = 16'h0;
			s_d.t_ses      = 16'h0;
			s_d.t_cses     = 16'h0;
			s_d.t_unsync   = 16'h0;
			s_d.t_secs     = 16'h0;
			s_d.t_run      = 4'h0;
			s_d.t_act      = 1'b0;
			s_d.ber        = 32'h0;
			s_d.div_busy   = 1'b0;
		end
		if (wb_req && WB_WE_I && WB_SEL_I[0] && ({WB_ADR_I[7:2], 2'b00} == BSM_ADR_CMD)
				&& WB_DAT_I[BSM_CMD_PCLR_BIT]) begin
			s_d.i_err_cnt = 24'h0;
			s_d.o_err_cnt = 24'h0;
			s_d.f_bit_cnt = 24'h0;
			s_d.i_es      = 16'h0;
			s_d.i_ses     = 16'h0;
			s_d.i_cses    = 16'h0;
			s_d.i_run     = 4'h0;
			s_d.i_act     = 1'b0;
			s_d.o_es      = 16'h0;
			s_d.o_ses     = 16'h0;
			s_d.o_cses    = 16'h0;
			s_d.o_run     = 4'h0;
			s_d.o_act     = 1'b0;
		end

		// Generator, one bit per slot strobe
		if (BIT_STB && running) begin
			s_d.tx_hist = {s_q.tx_hist[18:0], pat_bit(s_q.pat, s_q.tx_hist)};
			// one inverted bit; history keeps the clean bit so only one error is sent
			s_d.tx_bit   = pat_bit(s_q.pat, s_q.tx_hist) ^ s_q.inj_pend;
			s_d.inj_pend = 1'b0;
			s_d.bits_tot = s_d.bits_tot + 32'h1;
		end

		// Checker
		if (BIT_STB && running) begin
			s_d.rx_hist = {s_q.rx_hist[18:0], rx_bit};
			if (!s_q.sync) begin
				s_d.t_oos_flag = 1'b1;
				s_d.good_cnt   = bit_err ? 6'h00 : s_q.good_cnt + 6'h01;
				// sync after a run of matching bits
				if (!bit_err && (s_q.good_cnt == BSM_SYNC_GOOD_LST)) begin
					s_d.sync    = 1'b1;
					s_d.win_cnt = 7'h00;
					s_d.win_err = 4'h0;
				end
			end else begin
				if (bit_err) begin
					s_d.be_tot     = s_d.be_tot + 32'h1;
					s_d.t_err_cnt  = s_d.t_err_cnt + 24'h1;
					s_d.t_err_flag = 1'b1;
				end
				s_d.t_bit_cnt = s_d.t_bit_cnt + 24'h1;
				s_d.win_cnt   = s_q.win_cnt + 7'h01;
				if (bit_err && (s_q.win_err != 4'hF))
					s_d.win_err = s_q.win_err + 4'h1;
				// Dense errors in one window mean the lock is lost
				if (s_q.win_cnt == BSM_WIN_LAST) begin
					if (s_d.win_err >= BSM_LOSS_ERRS) begin
						s_d.sync     = 1'b0;
						s_d.good_cnt = 6'h00;
					end
					s_d.win_err = 4'h0;
				end
			end
		end
		if (!running) begin
			s_d.sync     = 1'b0;
			s_d.good_cnt = 6'h00;
		end

		// Tester per-second decisions
		if (tick && running) begin
			s_d.t_secs = s_d.t_secs + 16'h1;
			if (s_d.t_err_flag)
				s_d.t_es = s_d.t_es + 16'h1;
			sev_now = is_severe(s_d.t_err_cnt, s_d.t_bit_cnt);
			if (sev_now)
				s_d.t_ses = s_d.t_ses + 16'h1;
			step      = cses_step(sev_now, s_d.t_act, s_d.t_run);
			s_d.t_act = step[4];
			s_d.t_run = step[3:0];
			if (step[4])
				s_d.t_cses = s_d.t_cses + 16'h1;
			if (s_d.t_oos_flag || !s_q.sync)
				s_d.t_unsync = s_d.t_unsync + 16'h1;
			s_d.t_err_flag = 1'b0;
			s_d.t_oos_flag = 1'b0;
			s_d.t_err_cnt  = 24'h0;
			s_d.t_bit_cnt  = 24'h0;
		end
		// rate recomputed every tick, so it settles once the pattern stops
		if (tick) begin
			s_d.div_busy = 1'b1;
			s_d.div_cnt  = 6'h00;
			s_d.div_rem  = 33'h0;
			s_d.div_num  = {s_d.be_tot, 24'h0};
			s_d.div_den  = s_d.bits_tot;
		end else if (s_q.div_busy && s_d.div_busy) begin
			// serial divide, errors scaled by two to the 24
			div_try     = {s_q.div_rem[31:0], s_q.div_num[55]};
			s_d.div_num = {s_q.div_num[54:0], 1'b0};
			if (div_try >= {1'b0, s_q.div_den}) begin
				div_try        = div_try - {1'b0, s_q.div_den};
				s_d.div_num[0] = 1'b1;
			end
			s_d.div_rem = div_try;
			s_d.div_cnt = s_q.div_cnt + 6'h01;
			if (s_q.div_cnt == BSM_DIV_STEPS - 6'h01) begin
				s_d.div_busy = 1'b0;
				s_d.ber      = (s_q.div_den == 32'h0) ? 32'h0 : s_d.div_num[31:0];
			end
		end

		// Performance counters behind the correction stage
		if (FEC_BIT_STB && (s_q.fec != FEC_NONE)) begin
			s_d.f_bit_cnt = s_d.f_bit_cnt + 24'h1;
			if (FEC_IN_ERR)
				s_d.i_err_cnt = s_d.i_err_cnt + 24'h1;
			if (FEC_OUT_ERR && (s_q.fec == FEC_BCH))
				s_d.o_err_cnt = s_d.o_err_cnt + 24'h1;
		end
		if (tick) begin
			if (s_q.fec != FEC_NONE) begin
				if (s_d.i_err_cnt != 24'h0)
					s_d.i_es = s_d.i_es + 16'h1;
				sev_now = is_severe(s_d.i_err_cnt, s_d.f_bit_cnt);
				if (sev_now)
					s_d.i_ses = s_d.i_ses + 16'h1;
				step      = cses_step(sev_now, s_d.i_act, s_d.i_run);
				s_d.i_act = step[4];
				s_d.i_run = step[3:0];
				if (step[4])
					s_d.i_cses = s_d.i_cses + 16'h1;
			end
			if (s_q.fec == FEC_BCH) begin
				if (s_d.o_err_cnt != 24'h0)
					s_d.o_es = s_d.o_es + 16'h1;
				sev_now = is_severe(s_d.o_err_cnt, s_d.f_bit_cnt);
				if (sev_now)
					s_d.o_ses = s_d.o_ses + 16'h1;
				step      = cses_step(sev_now, s_d.o_act, s_d.o_run);
				s_d.o_act = step[4];
				s_d.o_run = step[3:0];
				if (step[4])
					s_d.o_cses = s_d.o_cses + 16'h1;
			end else begin
				s_d.o_act = 1'b0;
				s_d.o_run = 4'h0;
			end
			s_d.i_err_cnt = 24'h0;
			s_d.o_err_cnt = 24'h0;
			s_d.f_bit_cnt = 24'h0;
		end

		// Register writes last, so a fresh inject request is never eaten
		if (wb_req && WB_WE_I && WB_SEL_I[0]) begin
			case ({WB_ADR_I[7:2], 2'b00})
				BSM_ADR_CTRL: begin
					s_d.pat = bsm_pat_e'(WB_DAT_I[BSM_CTRL_PAT_LSB +: 3]);
					s_d.dir = WB_DAT_I[BSM_CTRL_DIR_BIT];
					// secondary refused when the port has none
					s_d.sec = WB_DAT_I[BSM_CTRL_SEC_BIT] & SEC_PRESENT;
					s_d.fec = bsm_fec_e'(WB_DAT_I[BSM_CTRL_FEC_LSB +: 2]);
				end
				BSM_ADR_CMD: begin
					if (WB_DAT_I[BSM_CMD_INJ_BIT])
						s_d.inj_pend = 1'b1;
				end
				default: begin
				end
			endcase
		end
		// fall back to primary if the secondary disappears
		if (!SEC_PRESENT)
			s_d.sec = 1'b0;
	end

	// Clock enable low freezes every flop, bus handshake included
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			s_q     <= '0;
			s_q.pat <= PAT_OFF;
			s_q.dir <= BSM_DIR_NET_RST;
			s_q.sec <= BSM_SEC_RST;
		end else if (CE) begin
			s_q <= s_d;
		end
	end

	assign WB_DAT_O    = s_q.rdat;
	assign WB_ACK_O    = s_q.ack;
	assign TST_TX_BIT  = s_q.tx_bit;
	// pattern steered to network or user side
	assign TST_NET_EN  = running & ~s_q.dir;
	assign TST_USER_EN = running & s_q.dir;
	assign TST_SEC_SEL = s_q.sec;

endmodule : bsm_top

`default_nettype wire
